//--- core/vac_consts.svh
`ifndef VAC_CONSTS_SVH
`define VAC_CONSTS_SVH

// ****************************************
// Sizes and timing
// ****************************************
`define VAC_DW             16
`define VAC_AW             6
`define VAC_RAW            7
`define VAC_FS             16'h4000
`define VAC_FS_BITS        14
`define VAC_SEG_LSB        10
`define VAC_FRAC_ONE       11'h400
`define VAC_DUTY_MAX       18'sh0FFFF
`define VAC_CLK_PERIOD_NS  5.0
`define VAC_CMD_SAMPLE_MS  1.0
`define VAC_LOOP_SAMPLE_MS 0.125
`define VAC_CMD_CYC  int'(`VAC_CMD_SAMPLE_MS * 1.0E6 / `VAC_CLK_PERIOD_NS)
`define VAC_LOOP_CYC int'(`VAC_LOOP_SAMPLE_MS * 1.0E6 / `VAC_CLK_PERIOD_NS)

// ****************************************
// Register map and fields
// ****************************************
`define VAC_REG_CTRL   7'h00
`define VAC_REG_UP_POS 7'h01
`define VAC_REG_DN_POS 7'h02
`define VAC_REG_UP_NEG 7'h03
`define VAC_REG_DN_NEG 7'h04
`define VAC_REG_MAX    7'h05
`define VAC_REG_MIN    7'h06
`define VAC_REG_TRIG   7'h07
`define VAC_REG_SCALE  7'h08
`define VAC_REG_GAIN   7'h09
`define VAC_REG_STATUS 7'h0A
`define VAC_REG_DEM_A  7'h0B
`define VAC_REG_DEM_B  7'h0C
`define VAC_MEM_SEL    6
`define VAC_MEM_PRESET 6'h00
`define VAC_MEM_PRAMP  6'h08
`define VAC_MEM_LIN    6'h10
`define VAC_CTRL_FN    1:0
`define VAC_CTRL_EN_B  2
`define VAC_CTRL_RAMP_MODE_SELECT 3
`define VAC_CTRL_CC    4
`define VAC_CTRL_S1F   5
`define VAC_FN_BIPOLAR 2'h0
`define VAC_FN_DUAL    2'h1
`define VAC_FN_PRESET  2'h2
`define VAC_CTRL_RST   16'h0000
`define VAC_RAMP_RST   16'h0000
`define VAC_MAX_RST    16'h0A28
`define VAC_MIN_RST    16'h0000
`define VAC_TRIG_RST   16'h0000
`define VAC_SCALE_RST  16'h4000
`define VAC_GAIN_RST   4'h4
`endif

//--- core/vac_pkg.sv
`default_nettype none
package vac_pkg;
  typedef logic [15:0]        vac_word_t;
  typedef logic signed [16:0] vac_cmd_t;
  typedef enum logic [2:0] {
    VAC_S_IDLE, VAC_S_PRE, VAC_S_RMP, VAC_S_RAMP, VAC_S_LO, VAC_S_HI, VAC_S_MIX
  } vac_seq_t;
endpackage : vac_pkg
`default_nettype wire

//--- core/vac_mem.sv
`timescale 1ns/1ps
`default_nettype none
module vac_mem #(
  parameter int DW = 16,
  parameter int AW = 6
) (
  // Clock
  input  wire logic          clk_in,
  // Write side
  input  wire logic          wr_in,
  input  wire logic [AW-1:0] waddr_in,
  input  wire logic [DW-1:0] wdata_in,
  // Read side
  input  wire logic [AW-1:0] raddr_in,
  output var  logic [DW-1:0] rdata_out
);
  if (DW < 1 || AW < 1) begin : g_bad_size
    $error("vac_mem: bad size");
  end

  logic [DW-1:0] mem_q [2**AW];

  // No reset: software loads the tables before use
  always_ff @(posedge clk_in) begin
    if (wr_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
    rdata_out <= mem_q[raddr_in];
  end
endmodule : vac_mem
`default_nettype wire

//--- core/vac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "vac_consts.svh"
module vac_top #(
  parameter int CMD_CYC  = `VAC_CMD_CYC,
  parameter int LOOP_CYC = `VAC_LOOP_CYC
) (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  // Register port
  input  wire logic [`VAC_RAW-1:0]  reg_addr_in,
  input  wire vac_pkg::vac_word_t   reg_wdata_in,
  input  wire logic                 reg_wr_in,
  input  wire logic                 reg_rd_in,
  output var  vac_pkg::vac_word_t   reg_rdata_out,
  // Digital pins
  input  wire logic                 enable_in,
  input  wire logic                 enable_b_in,
  input  wire logic                 select_line_one_in,
  input  wire logic                 select_line_two_in,
  input  wire logic                 select_line_four_in,
  // Converted commands, same clock
  input  wire vac_pkg::vac_word_t   command_channel_one_in,
  input  wire vac_pkg::vac_word_t   command_channel_two_in,
  // Current sense and stage faults
  input  wire vac_pkg::vac_word_t   sense_current_a_in,
  input  wire vac_pkg::vac_word_t   sense_current_b_in,
  input  wire logic [1:0]           cable_break_in,
  input  wire logic [1:0]           short_circuit_in,
  // Status and power stage
  output var  logic                 ready_out,
  output var  logic [1:0]           stage_en_out,
  output var  vac_pkg::vac_word_t   pwm_duty_a_out,
  output var  vac_pkg::vac_word_t   pwm_duty_b_out
);
  import vac_pkg::*;

  // ****************************************
  // Tick generation
  // ****************************************
  localparam int CCW = $clog2(CMD_CYC + 1);
  localparam int LCW = $clog2(LOOP_CYC + 1);
  if (LOOP_CYC < 1 || CMD_CYC < LOOP_CYC) begin : g_bad_ticks
    $error("vac_top: tick counts out of range");
  end

  logic [CCW-1:0] cmd_cnt_q;
  logic [LCW-1:0] loop_cnt_q;
  logic           cmd_tick_q;
  logic           loop_tick_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cmd_cnt_q   <= '0;
      loop_cnt_q  <= '0;
      cmd_tick_q  <= 1'b0;
      loop_tick_q <= 1'b0;
    end else begin
      cmd_tick_q  <= (cmd_cnt_q == CCW'(CMD_CYC - 1));
      loop_tick_q <= (loop_cnt_q == LCW'(LOOP_CYC - 1));
      cmd_cnt_q   <= (cmd_cnt_q == CCW'(CMD_CYC - 1)) ? '0 : cmd_cnt_q + 1'b1;
      loop_cnt_q  <= (loop_cnt_q == LCW'(LOOP_CYC - 1)) ? '0 : loop_cnt_q + 1'b1;
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [8:0] meta_q;
  logic [8:0] pin_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      pin_q  <= '0;
    end else begin
      meta_q <= {short_circuit_in, cable_break_in, select_line_four_in,
                 select_line_two_in, select_line_one_in, enable_b_in, enable_in};
      pin_q  <= meta_q;
    end
  end

  logic       en_s;
  logic       s1_s;
  logic [2:0] idx_s;
  logic [1:0] fault_s;
  assign en_s    = pin_q[0];
  assign s1_s    = pin_q[2];
  assign idx_s   = pin_q[4:2];
  assign fault_s = pin_q[6:5] | pin_q[8:7];

  // ****************************************
  // Registers
  // ****************************************
  vac_word_t ctrl_q;
  vac_word_t up_pos_q;
  vac_word_t dn_pos_q;
  vac_word_t up_neg_q;
  vac_word_t dn_neg_q;
  vac_word_t max_q;
  vac_word_t min_q;
  vac_word_t trig_q;
  vac_word_t scale_q;
  logic [3:0] gain_q;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_q   <= `VAC_CTRL_RST;
      up_pos_q <= `VAC_RAMP_RST;
      dn_pos_q <= `VAC_RAMP_RST;
      up_neg_q <= `VAC_RAMP_RST;
      dn_neg_q <= `VAC_RAMP_RST;
      max_q    <= `VAC_MAX_RST;
      min_q    <= `VAC_MIN_RST;
      trig_q   <= `VAC_TRIG_RST;
      scale_q  <= `VAC_SCALE_RST;
      gain_q   <= `VAC_GAIN_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `VAC_REG_CTRL:   ctrl_q   <= reg_wdata_in;
        `VAC_REG_UP_POS: up_pos_q <= reg_wdata_in;
        `VAC_REG_DN_POS: dn_pos_q <= reg_wdata_in;
        `VAC_REG_UP_NEG: up_neg_q <= reg_wdata_in;
        `VAC_REG_DN_NEG: dn_neg_q <= reg_wdata_in;
        `VAC_REG_MAX:    max_q    <= reg_wdata_in;
        `VAC_REG_MIN:    min_q    <= reg_wdata_in;
        `VAC_REG_TRIG:   trig_q   <= reg_wdata_in;
        `VAC_REG_SCALE:  scale_q  <= reg_wdata_in;
        `VAC_REG_GAIN:   gain_q   <= reg_wdata_in[3:0];
        default: ;
      endcase
    end
  end

  logic is_dual;
  logic is_pre;
  logic is_bip;
  assign is_dual = ctrl_q[`VAC_CTRL_FN] == `VAC_FN_DUAL;
  assign is_pre  = ctrl_q[`VAC_CTRL_FN] == `VAC_FN_PRESET;
  assign is_bip  = !is_dual && !is_pre;

  // ****************************************
  // Enables, errors and ready
  // ****************************************
  logic [1:0] en_ch;
  logic [1:0] err_q;
  logic       err_any;
  logic [1:0] act_v;
  logic       ready_q;
  logic [1:0] stage_q;

  assign en_ch[0] = en_s;
  assign en_ch[1] = (is_dual && ctrl_q[`VAC_CTRL_EN_B]) ? pin_q[1] : en_s;
  assign err_any  = |err_q;
  assign act_v    = en_ch & {2{!err_any}};

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      err_q   <= '0;
      ready_q <= 1'b0;
      stage_q <= '0;
    end else begin
      err_q   <= fault_s | (err_q & en_ch);
      ready_q <= !err_any && (is_dual ? |en_ch : en_s);
      stage_q <= act_v;
    end
  end

  // ****************************************
  // Table memory and sequencer
  // ****************************************
  vac_seq_t          state_q;
  logic              ch_q;
  logic [`VAC_AW-1:0] raddr_v;
  vac_word_t         mem_rdata;
  vac_word_t         pre_q;
  vac_word_t         lo_q;
  logic [3:0]        seg_v;

  vac_mem #(.DW(`VAC_DW), .AW(`VAC_AW)) u_mem (
    .clk_in    (ref_clk_in),
    .wr_in     (reg_wr_in && reg_addr_in[`VAC_MEM_SEL]),
    .waddr_in  (reg_addr_in[`VAC_AW-1:0]),
    .wdata_in  (reg_wdata_in),
    .raddr_in  (raddr_v),
    .rdata_out (mem_rdata)
  );

  always_comb begin
    case (state_q)
      VAC_S_PRE: raddr_v = `VAC_MEM_PRESET + {3'h0, idx_s};
      VAC_S_RMP: raddr_v = `VAC_MEM_PRAMP + {3'h0, idx_s};
      VAC_S_LO:  raddr_v = `VAC_MEM_LIN + {2'h0, seg_v};
      VAC_S_HI:  raddr_v = `VAC_MEM_LIN + {2'h0, seg_v} + 6'h01;
      default:   raddr_v = '0;
    endcase
  end

  // Mode changes mid-sample only cost one stale sample
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= VAC_S_IDLE;
      ch_q    <= 1'b0;
    end else begin
      unique case (state_q)
        VAC_S_IDLE: begin
          ch_q <= 1'b0;
          if (cmd_tick_q) begin
            state_q <= VAC_S_PRE;
          end
        end
        VAC_S_PRE:  state_q <= VAC_S_RMP;
        VAC_S_RMP:  state_q <= VAC_S_RAMP;
        VAC_S_RAMP: state_q <= VAC_S_LO;
        VAC_S_LO:   state_q <= VAC_S_HI;
        VAC_S_HI:   state_q <= VAC_S_MIX;
        VAC_S_MIX: begin
          ch_q    <= is_dual && !ch_q;
          state_q <= (is_dual && !ch_q) ? VAC_S_LO : VAC_S_IDLE;
        end
        default:    state_q <= VAC_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pre_q <= '0;
      lo_q  <= '0;
    end else begin
      if (state_q == VAC_S_RMP) begin
        pre_q <= mem_rdata;
      end
      if (state_q == VAC_S_HI) begin
        lo_q <= mem_rdata;
      end
    end
  end

  // ****************************************
  // Ramps
  // ****************************************
  vac_cmd_t  cur0_q;
  vac_cmd_t  cur1_q;
  vac_cmd_t  tgt0_v;
  vac_cmd_t  tgt1_v;
  vac_word_t step0_v;
  vac_word_t step1_v;

  function automatic vac_cmd_t vac_sat(input vac_cmd_t x, input vac_cmd_t lo);
    return (x < lo) ? lo : ((x > vac_cmd_t'(`VAC_FS)) ? vac_cmd_t'(`VAC_FS) : x);
  endfunction : vac_sat

  // Zero step means jump straight to the target
  function automatic vac_cmd_t vac_move(input vac_cmd_t cur, input vac_cmd_t tgt,
                                        input vac_word_t step);
    vac_cmd_t st;
    st = vac_cmd_t'({1'b0, step});
    if (step == '0) begin
      return tgt;
    end
    if (tgt > cur) begin
      return (tgt - cur > st) ? cur + st : tgt;
    end
    return (cur - tgt > st) ? cur - st : tgt;
  endfunction : vac_move

  function automatic vac_word_t vac_quad(input vac_cmd_t cur, input vac_cmd_t tgt);
    if (cur > 0 || (cur == 0 && tgt > 0)) begin
      return (tgt > cur) ? up_pos_q : dn_pos_q;
    end
    return (tgt < cur) ? up_neg_q : dn_neg_q;
  endfunction : vac_quad

  always_comb begin
    if (is_pre) begin
      tgt0_v = vac_sat(vac_cmd_t'($signed(pre_q)), -vac_cmd_t'(`VAC_FS));
    end else if (is_dual) begin
      tgt0_v = vac_sat(vac_cmd_t'($signed(command_channel_one_in)), '0);
    end else begin
      tgt0_v = vac_sat(vac_cmd_t'($signed(command_channel_one_in)), -vac_cmd_t'(`VAC_FS));
    end
    tgt1_v = vac_sat(vac_cmd_t'($signed(command_channel_two_in)), '0);
    // Pass through zero so each side uses its own fall time
    if ((cur0_q > 0 && tgt0_v < 0) || (cur0_q < 0 && tgt0_v > 0)) begin
      tgt0_v = '0;
    end
    if (is_dual) begin
      step0_v = (tgt0_v > cur0_q) ? up_pos_q : dn_pos_q;
    end else if (is_pre && ctrl_q[`VAC_CTRL_RAMP_MODE_SELECT]) begin
      step0_v = mem_rdata;
    end else if (is_bip && ctrl_q[`VAC_CTRL_S1F] && !s1_s) begin
      step0_v = '0;
    end else begin
      step0_v = vac_quad(cur0_q, tgt0_v);
    end
    step1_v = (tgt1_v > cur1_q) ? up_neg_q : dn_neg_q;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !act_v[0]) begin
      cur0_q <= '0;
    end else if (state_q == VAC_S_RAMP) begin
      cur0_q <= vac_move(cur0_q, tgt0_v, step0_v);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !act_v[1] || !is_dual) begin
      cur1_q <= '0;
    end else if (state_q == VAC_S_RAMP) begin
      cur1_q <= vac_move(cur1_q, tgt1_v, step1_v);
    end
  end

  // ****************************************
  // Scaling, linearization, adaptation
  // ****************************************
  vac_word_t                m_v;
  vac_word_t                m2_v;
  vac_word_t                lin_v;
  vac_word_t                span_v;
  vac_word_t                adapt_v;
  logic [10:0]              frac_v;
  logic [31:0]              prod_v;
  logic [31:0]              prod2_v;
  logic [16:0]              sum_v;
  logic signed [16:0]       dl_v;
  logic signed [28:0]       mul_v;
  logic [1:0][`VAC_DW-1:0]  dem_q;

  always_comb begin
    m_v = ch_q ? cur1_q[15:0] : ((cur0_q < 0) ? 16'(-cur0_q) : cur0_q[15:0]);
    prod_v = 32'(m_v) * 32'(scale_q);
    if (is_bip && !ctrl_q[`VAC_CTRL_S1F] && !s1_s) begin
      m_v = prod_v[`VAC_FS_BITS+15:`VAC_FS_BITS];
    end
    if (m_v > `VAC_FS) begin
      m_v = `VAC_FS;
    end
    seg_v  = (m_v >= `VAC_FS) ? 4'hF : m_v[`VAC_FS_BITS-1:`VAC_SEG_LSB];
    frac_v = (m_v >= `VAC_FS) ? `VAC_FRAC_ONE : {1'b0, m_v[`VAC_SEG_LSB-1:0]};
    dl_v   = $signed({1'b0, mem_rdata}) - $signed({1'b0, lo_q});
    mul_v  = dl_v * $signed({1'b0, frac_v});
    lin_v  = 16'($signed({1'b0, lo_q}) + 17'(mul_v >>> `VAC_SEG_LSB));
    m2_v   = ctrl_q[`VAC_CTRL_CC] ? lin_v : m_v;
    if (m2_v > `VAC_FS) begin
      m2_v = `VAC_FS;
    end
    span_v  = (max_q > min_q) ? max_q - min_q : '0;
    prod2_v = 32'(m2_v) * 32'(span_v);
    sum_v   = 17'(min_q) + 17'(prod2_v >> `VAC_FS_BITS);
    if (m2_v <= trig_q) begin
      adapt_v = '0;
    end else begin
      adapt_v = (sum_v > 17'(max_q)) ? max_q : sum_v[15:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      dem_q <= '0;
    end else begin
      if (state_q == VAC_S_MIX) begin
        if (is_dual) begin
          dem_q[ch_q] <= adapt_v;
        end else begin
          dem_q[0] <= (cur0_q > 0) ? adapt_v : '0;
          dem_q[1] <= (cur0_q < 0) ? adapt_v : '0;
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (!act_v[i]) begin
          dem_q[i] <= '0;
        end
      end
    end
  end

  // ****************************************
  // Current loops
  // ****************************************
  for (genvar i = 0; i < 2; i++) begin : g_loop
    logic signed [17:0] err_v;
    logic signed [17:0] nxt_v;
    vac_word_t          duty_q;
    assign err_v = $signed({2'h0, dem_q[i]})
                 - $signed({2'h0, (i == 0) ? sense_current_a_in : sense_current_b_in});
    assign nxt_v = $signed({2'h0, duty_q}) + (err_v >>> gain_q);
    // Integral action: duty settles where coil current meets demand
    always_ff @(posedge ref_clk_in) begin
      if (rst_in || !act_v[i]) begin
        duty_q <= '0;
      end else if (loop_tick_q) begin
        duty_q <= (nxt_v < 0) ? '0 : ((nxt_v > `VAC_DUTY_MAX) ? 16'hFFFF : nxt_v[15:0]);
      end
    end
  end

  // ****************************************
  // Read port and outputs
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !reg_rd_in) begin
      reg_rdata_out <= '0;
    end else begin
      case (reg_addr_in)
        `VAC_REG_CTRL:   reg_rdata_out <= ctrl_q;
        `VAC_REG_UP_POS: reg_rdata_out <= up_pos_q;
        `VAC_REG_DN_POS: reg_rdata_out <= dn_pos_q;
        `VAC_REG_UP_NEG: reg_rdata_out <= up_neg_q;
        `VAC_REG_DN_NEG: reg_rdata_out <= dn_neg_q;
        `VAC_REG_MAX:    reg_rdata_out <= max_q;
        `VAC_REG_MIN:    reg_rdata_out <= min_q;
        `VAC_REG_TRIG:   reg_rdata_out <= trig_q;
        `VAC_REG_SCALE:  reg_rdata_out <= scale_q;
        `VAC_REG_GAIN:   reg_rdata_out <= {12'h000, gain_q};
        `VAC_REG_STATUS: reg_rdata_out <= {9'h000, err_q, stage_q, en_ch, ready_q};
        `VAC_REG_DEM_A:  reg_rdata_out <= dem_q[0];
        `VAC_REG_DEM_B:  reg_rdata_out <= dem_q[1];
        default:         reg_rdata_out <= '0;
      endcase
    end
  end

  assign ready_out      = ready_q;
  assign stage_en_out   = stage_q;
  assign pwm_duty_a_out = g_loop[0].duty_q;
  assign pwm_duty_b_out = g_loop[1].duty_q;

  // ****************************************
  // Checks
  // ****************************************
  AST_READY_ERR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    err_any |=> !ready_out) else $error("ready high with error");
  AST_READY_EN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!is_dual && !en_s) |=> !ready_out) else $error("ready high without enable");
  AST_READY_DUAL: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (is_dual && en_ch == 2'b00) |=> !ready_out) else $error("dual ready with no enable");
  AST_START: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!is_dual && en_s && !err_any) |=> ready_out && stage_en_out == 2'b11)
    else $error("enable did not start outputs");
  AST_ERR_CLR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!en_s && fault_s == 2'b00 && !is_dual) |=> err_q == 2'b00) else $error("error not cleared");
  AST_STAGE_OFF: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    err_any |=> stage_en_out == 2'b00 && pwm_duty_a_out == '0 && pwm_duty_b_out == '0)
    else $error("stage active during error");
  AST_ZERO_DEM: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !act_v[0] |=> dem_q[0] == '0 && cur0_q == '0) else $error("demand held while disabled");
  AST_ONE_SIDE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (!is_dual && !$past(is_dual) && dem_q[0] != '0) |-> dem_q[1] == '0)
    else $error("both solenoids driven");
  AST_MAX_CAP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == VAC_S_MIX |-> adapt_v <= max_q) else $error("output above maximum");
  AST_SHARED_EN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    (is_dual && !ctrl_q[`VAC_CTRL_EN_B] && !en_s) |-> act_v == 2'b00)
    else $error("channel active without shared enable");
endmodule : vac_top
`default_nettype wire

//--- tb/vac_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Controller at the command and enable pins
// ****************************************
module vac_plc_model (
  // Clock and requests
  input  wire logic                clk_in,
  input  wire logic                en_req_in,
  input  wire logic                en_b_req_in,
  input  wire logic [2:0]          sel_req_in,
  input  wire vac_pkg::vac_word_t  cmd_a_req_in,
  input  wire vac_pkg::vac_word_t  cmd_b_req_in,
  // Pins
  output var  logic                enable_out,
  output var  logic                enable_b_out,
  output var  logic [2:0]          sel_out,
  output var  vac_pkg::vac_word_t  cmd_a_out,
  output var  vac_pkg::vac_word_t  cmd_b_out
);
  import vac_pkg::*;
  // One cycle of lag, like a real output card
  always_ff @(posedge clk_in) begin
    enable_out   <= en_req_in;
    enable_b_out <= en_b_req_in;
    sel_out      <= sel_req_in;
    cmd_a_out    <= cmd_a_req_in;
    cmd_b_out    <= cmd_b_req_in;
  end
endmodule : vac_plc_model
`default_nettype wire

//--- tb/valve_amplifier_command_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "vac_consts.svh"
module valve_amplifier_command_logic_tb;
  import vac_pkg::*;
  localparam int CMD = 64;
  logic clk, rst, wr, rd, en, en_b, ready, enp, enbp;
  logic [6:0] addr;
  logic [2:0] sel, selp;
  logic [1:0] brk, shrt, stage;
  vac_word_t wdata, rdata, ca, cb, cap, cbp, pre [8];
  vac_word_t da, db;  // Coil current read back equal to duty
  int num_errors, n_tests, seed, c, mn, tr;
  vac_plc_model plc (.clk_in(clk), .en_req_in(en), .en_b_req_in(en_b), .sel_req_in(sel),
    .cmd_a_req_in(ca), .cmd_b_req_in(cb), .enable_out(enp), .enable_b_out(enbp),
    .sel_out(selp), .cmd_a_out(cap), .cmd_b_out(cbp));
  vac_top #(.CMD_CYC(CMD), .LOOP_CYC(8)) dut (.ref_clk_in(clk), .rst_in(rst),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .enable_in(enp), .enable_b_in(enbp),
    .select_line_one_in(selp[0]), .select_line_two_in(selp[1]),
    .select_line_four_in(selp[2]), .command_channel_one_in(cap),
    .command_channel_two_in(cbp), .sense_current_a_in(da),
    .sense_current_b_in(db), .cable_break_in(brk), .short_circuit_in(shrt),
    .ready_out(ready), .stage_en_out(stage), .pwm_duty_a_out(da), .pwm_duty_b_out(db));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // ****************************************
  // Bus cycles and comparisons
  // ****************************************
  task automatic reg_wr(input logic [6:0] a, input vac_word_t d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic chk_reg(input string nm, input logic [6:0] a, input vac_word_t e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    n_tests++;
    if (rdata !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, rdata);
    end
  endtask : chk_reg
  task automatic chk_pin(input string nm, input logic [1:0] e, input logic [1:0] s);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_pin
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle
  // Integral loop settles within one gain step below demand
  task automatic chk_duty(input string nm, input vac_word_t e, input vac_word_t s);
    n_tests++;
    if ($isunknown(s) || s > e || e - s > 16'h000F) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_duty
  // Zero up to trigger, then MIN plus a share of the span
  function automatic vac_word_t exp_dem(input int m);
    int v;
    if (m <= tr) return 16'h0000;
    v = mn + m * (32'h0A28 - mn) / 32'h4000;
    if (v > 32'h0A28) v = 32'h0A28;
    return v[15:0];
  endfunction : exp_dem
  task automatic chk_dem(input int m);
    settle(20 * CMD);
    chk_duty("duty_a", exp_dem(m), da);
    chk_duty("duty_b", exp_dem(-m), db);
    chk_reg("dem_a", 7'h0B, exp_dem(m));
    chk_reg("dem_b", 7'h0C, exp_dem(-m));
  endtask : chk_dem
  task automatic stop_test;
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst, wr, rd, en, en_b, sel, brk, shrt, addr, wdata, ca, cb} = '0;
    rst = 1'b1;
    num_errors = 0; n_tests = 0; seed = 47951;
    {mn, tr} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_reg("ctrl", 7'h00, 16'h0000);
    chk_reg("max", 7'h05, 16'h0A28);
    chk_reg("scale", 7'h08, 16'h4000);
    chk_reg("gain", 7'h09, 16'h0004);
    chk_reg("unmapped", 7'h0D, 16'h0000);
    chk_reg("table", 7'h40, 16'h0000);
    chk_pin("ready", 2'b00, {1'b0, ready});
    en <= 1'b1;
    settle(8);
    chk_pin("ready", 2'b01, {1'b0, ready});
    for (int i = 0; i < 9; i++) begin
      c = (i == 0) ? 32'h4000 : (i == 1) ? -32'h4000 : (i == 2) ? 0 : $random(seed) % int'(32'h4001);
      ca <= c[15:0];
      sel <= 3'($random(seed));
      chk_dem(c);
    end
    reg_wr(7'h06, 16'h0100);
    reg_wr(7'h07, 16'h1000);
    mn = 32'h0100;
    tr = 32'h1000;
    ca <= 16'h0800;
    chk_dem(32'h0800);
    ca <= 16'hE000;
    chk_dem(-32'h2000);
    // Preset table first: the preset path must never use an unwritten preset word
    for (int i = 0; i < 8; i++) begin
      c = $random(seed) % int'(32'h4001);
      pre[i] = c[15:0];
      reg_wr(7'h40 + 7'(i), pre[i]);
    end
    reg_wr(7'h00, 16'h0002);
    for (int i = 7; i >= 0; i--) begin
      sel <= 3'(i);
      chk_dem(int'($signed(pre[i])));
    end
    brk <= 2'b01;
    settle(8);
    chk_pin("ready", 2'b00, {1'b0, ready});
    chk_pin("stage", 2'b00, stage);
    brk <= 2'b00;
    chk_dem(0);
    chk_pin("ready", 2'b00, {1'b0, ready});
    en <= 1'b0;
    settle(8);
    en <= 1'b1;
    settle(8);
    chk_pin("ready", 2'b01, {1'b0, ready});
    reg_wr(7'h00, 16'h0005);
    en <= 1'b0;
    cb <= 16'h2000;
    settle(8);
    chk_pin("ready", 2'b00, {1'b0, ready});
    en_b <= 1'b1;
    settle(8);
    chk_pin("ready", 2'b01, {1'b0, ready});
    settle(20 * CMD);
    chk_reg("dem_a", 7'h0B, 16'h0000);
    chk_pin("stage", 2'b10, stage);
    chk_duty("duty_b", exp_dem(32'h2000), db);
    chk_reg("dem_b", 7'h0C, exp_dem(32'h2000));
    stop_test;
  end
endmodule : valve_amplifier_command_logic_tb
`default_nettype wire
